// ### psdp_sram_port.sv
// pipelined burst sram data port with axi4-lite control and status
//
// Design decisions made here: register access over AXI4-Lite and the register addresses.
`timescale 1ns/10ps

// Functional notes
// - qualify low at a rising edge makes it a real edge; inputs sampled.
// - qualify high ignores the edge; only output enable is still sampled, no other sram pipeline state advances.
// - qualify high does not deselect; the current cycle just stretches.
// - input data lanes are captured on the rising edge straight into the lane array.
// - read data appears one cycle after its address edge.
// - output enable low plus internal read state lets lanes drive.
// - output enable high floats every data lane.
// - lanes float in write data phase, after deselect, and while deselected.
// - parity lanes act as data lanes, written under their byte select.
// - burst order strap high gives interleaved, low gives linear order.
// - a floating strap is taken as high, interleaved.
// - each byte select, with write request, enables its byte and parity.
// - advance high steps burst counter; low loads a new address.
// - selected only when select a low, select b high, select c low.
module psdp_sram_port #(
    parameter int unsigned ADDR_W = 18,
    parameter int unsigned LANES = 4
) (
    input wire logic core_clk,
    input wire logic rst_n,
    input wire logic clkQualifyN,
    input wire psdp_pkg::psdp_ctrl_s ctrlPins,
    input wire logic [LANES-1:0] byteLaneWriteN,
    input wire logic [ADDR_W-1:0] address,
    input wire logic outputEnableN,
    input wire logic burstOrder,
    input wire logic [LANES*8-1:0] dataIn,
    output logic [LANES*8-1:0] dataOut,
    output logic [LANES-1:0] dataOe,
    input wire logic [LANES-1:0] parityIoLanesIn,
    output logic [LANES-1:0] parityIoLanesOut,
    output logic [LANES-1:0] parityIoLanesOe,
    input wire logic [7:0] awaddr,
    input wire logic awvalid,
    output logic awready,
    input wire logic [31:0] wdata,
    input wire logic [3:0] wstrb,
    input wire logic wvalid,
    output logic wready,
    output logic [1:0] bresp,
    output logic bvalid,
    input wire logic bready,
    input wire logic [7:0] araddr,
    input wire logic arvalid,
    output logic arready,
    output logic [31:0] rdata,
    output logic [1:0] rresp,
    output logic rvalid,
    input wire logic rready
);

    localparam int unsigned DEPTH = 1 << ADDR_W;
    localparam int unsigned LW = psdp_pkg::LANE_W;
    localparam int unsigned LDW = psdp_pkg::LANE_DATA_W;

    // ---------------- sram pipeline ----------------
    logic qualified;
    logic selected;
    logic modeInterleaved_q, modeInterleaved_d;
    logic [ADDR_W-1:0] base_q, base_d;
    logic [1:0] beat_q, beat_d;
    psdp_pkg::psdp_op_e burstOp_q, burstOp_d;
    logic [LANES-1:0] laneSelA_q, laneSelA_d;
    logic [ADDR_W-1:0] addrA;
    logic [1:0] burstLow;
    psdp_pkg::psdp_op_e opB_q, opB_d;
    logic [ADDR_W-1:0] addrB_q, addrB_d;
    logic [LANES-1:0] laneSelB_q, laneSelB_d;
    logic drive_q, drive_d;
    logic [LANES*8-1:0] dataOut_q, dataOut_d;
    logic [LANES-1:0] parOut_q, parOut_d;
    logic [LANES-1:0] oe_q, oe_d;
    logic [LW-1:0] rdLane [LANES];
    logic writeProtect;
    logic [psdp_pkg::BEATS_W-1:0] rdBeats_q, rdBeats_d;
    logic [psdp_pkg::BEATS_W-1:0] wrBeats_q, wrBeats_d;

    assign qualified = ~clkQualifyN;
    assign selected = ~ctrlPins.selectAN & ctrlPins.selectB & ~ctrlPins.selectCN;

    psdp_burst_seq u_burst (
        .startLow(base_q[1:0]),
        .beat(beat_q),
        .interleaved(modeInterleaved_q),
        .burstLow(burstLow)
    );

    assign addrA = {base_q[ADDR_W-1:2], burstLow};

    always_comb begin
        modeInterleaved_d = modeInterleaved_q;
        base_d = base_q;
        beat_d = beat_q;
        burstOp_d = burstOp_q;
        laneSelA_d = laneSelA_q;
        opB_d = opB_q;
        addrB_d = addrB_q;
        laneSelB_d = laneSelB_q;
        drive_d = drive_q;
        dataOut_d = dataOut_q;
        parOut_d = parOut_q;
        rdBeats_d = rdBeats_q;
        wrBeats_d = wrBeats_q;
        if (qualified) begin
            if (ctrlPins.advanceOrLoad) begin
                // advancing from deselect stays deselected; op type kept for burst
                if (burstOp_q != psdp_pkg::OP_IDLE) begin
                    beat_d = 2'(beat_q + 2'h1);
                end
            end else if (selected) begin
                base_d = address;
                beat_d = 2'h0;
                burstOp_d = ctrlPins.writeReqN ? psdp_pkg::OP_READ : psdp_pkg::OP_WRITE;
            end else begin
                burstOp_d = psdp_pkg::OP_IDLE;
            end
            laneSelA_d = byteLaneWriteN;
            opB_d = burstOp_q;
            addrB_d = addrA;
            laneSelB_d = laneSelA_q;
            if (burstOp_q == psdp_pkg::OP_READ) begin
                for (int i = 0; i < LANES; i++) begin
                    dataOut_d[i*LDW +: LDW] = rdLane[i][LDW-1:0];
                    parOut_d[i] = rdLane[i][LDW];
                end
                rdBeats_d = psdp_pkg::BEATS_W'(rdBeats_q + 1'b1);
            end
            if (burstOp_q == psdp_pkg::OP_WRITE) begin
                wrBeats_d = psdp_pkg::BEATS_W'(wrBeats_q + 1'b1);
            end
            drive_d = (burstOp_q == psdp_pkg::OP_READ);
        end
    end

    // enable high floats lanes
    // oe pin is registered, not qualified; it is sampled on every edge, qualified or not
    always_comb begin
        oe_d = {LANES{drive_d & ~outputEnableN}};
    end

    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            // float reads high at pin pad
            modeInterleaved_q <= burstOrder;
            base_q <= '0;
            beat_q <= 2'h0;
            burstOp_q <= psdp_pkg::OP_IDLE;
            laneSelA_q <= '1;
            opB_q <= psdp_pkg::OP_IDLE;
            addrB_q <= '0;
            laneSelB_q <= '1;
            drive_q <= 1'b0;
            dataOut_q <= '0;
            parOut_q <= '0;
            oe_q <= '0;
            rdBeats_q <= '0;
            wrBeats_q <= '0;
        end else begin
            modeInterleaved_q <= modeInterleaved_d;
            base_q <= base_d;
            beat_q <= beat_d;
            burstOp_q <= burstOp_d;
            laneSelA_q <= laneSelA_d;
            opB_q <= opB_d;
            addrB_q <= addrB_d;
            laneSelB_q <= laneSelB_d;
            drive_q <= drive_d;
            dataOut_q <= dataOut_d;
            parOut_q <= parOut_d;
            oe_q <= oe_d;
            rdBeats_q <= rdBeats_d;
            wrBeats_q <= wrBeats_d;
        end
    end

    assign dataOut = dataOut_q;
    assign parityIoLanesOut = parOut_q;
    assign dataOe = oe_q;
    assign parityIoLanesOe = oe_q;

    // one array per lane so a partial write touches only its own bits
    for (genvar g = 0; g < LANES; g++) begin : g_lane
        logic [LW-1:0] lane [DEPTH];
        logic laneWe;
        assign rdLane[g] = lane[addrA];
        assign laneWe = qualified & (opB_q == psdp_pkg::OP_WRITE) & ~laneSelB_q[g] & ~writeProtect;
        always_ff @(posedge core_clk) begin
            if (rst_n && laneWe) begin
                lane[addrB_q] <= {parityIoLanesIn[g], dataIn[g*LDW +: LDW]};
            end
        end
    end

    // ---------------- axi4-lite slave ----------------
    logic awHave_q, awHave_d;
    logic wHave_q, wHave_d;
    logic [7:0] awAddr_q, awAddr_d;
    logic [31:0] wData_q, wData_d;
    logic [3:0] wStrb_q, wStrb_d;
    logic bvalid_q, bvalid_d;
    logic [1:0] bresp_q, bresp_d;
    logic rvalid_q, rvalid_d;
    logic [31:0] rdata_q, rdata_d;
    logic [1:0] rresp_q, rresp_d;
    logic [31:0] ctrl_q, ctrl_d;
    logic [31:0] statusWord;
    logic [31:0] beatsWord;

    assign writeProtect = ctrl_q[psdp_pkg::CTRL_WPROT_BIT];

    always_comb begin
        statusWord = '0;
        statusWord[psdp_pkg::STAT_INTERLEAVED_BIT] = modeInterleaved_q;
        statusWord[psdp_pkg::STAT_BURST_ACTIVE_BIT] = (burstOp_q != psdp_pkg::OP_IDLE);
        statusWord[psdp_pkg::STAT_BURST_WRITE_BIT] = (burstOp_q == psdp_pkg::OP_WRITE);
        statusWord[psdp_pkg::STAT_DRIVING_BIT] = drive_q;
        beatsWord = '0;
        beatsWord[psdp_pkg::BEATS_RD_LSB +: psdp_pkg::BEATS_W] = rdBeats_q;
        beatsWord[psdp_pkg::BEATS_WR_LSB +: psdp_pkg::BEATS_W] = wrBeats_q;
    end

    always_comb begin
        awHave_d = awHave_q;
        wHave_d = wHave_q;
        awAddr_d = awAddr_q;
        wData_d = wData_q;
        wStrb_d = wStrb_q;
        bvalid_d = bvalid_q;
        bresp_d = bresp_q;
        rvalid_d = rvalid_q;
        rdata_d = rdata_q;
        rresp_d = rresp_q;
        ctrl_d = ctrl_q;
        if (awvalid && !awHave_q) begin
            awHave_d = 1'b1;
            awAddr_d = awaddr;
        end
        if (wvalid && !wHave_q) begin
            wHave_d = 1'b1;
            wData_d = wdata;
            wStrb_d = wstrb;
        end
        if (bvalid_q && bready) begin
            bvalid_d = 1'b0;
        end
        // one cycle after both halves arrive, response waits for bready
        if (awHave_q && wHave_q && !bvalid_q) begin
            awHave_d = 1'b0;
            wHave_d = 1'b0;
            bvalid_d = 1'b1;
            bresp_d = psdp_pkg::RESP_OKAY;
            if (awAddr_q[7:2] == psdp_pkg::REG_CTRL[7:2]) begin
                for (int b = 0; b < 4; b++) begin
                    if (wStrb_q[b]) begin
                        ctrl_d[b*8 +: 8] = wData_q[b*8 +: 8];
                    end
                end
            end else if (awAddr_q[7:2] == psdp_pkg::REG_STATUS[7:2]) begin
                bresp_d = psdp_pkg::RESP_OKAY;
            end else if (awAddr_q[7:2] == psdp_pkg::REG_BEATS[7:2]) begin
                bresp_d = psdp_pkg::RESP_OKAY;
            end else begin
                bresp_d = psdp_pkg::RESP_SLVERR;
            end
        end
        if (rvalid_q && rready) begin
            rvalid_d = 1'b0;
        end
        if (arvalid && !rvalid_q) begin
            rvalid_d = 1'b1;
            rresp_d = psdp_pkg::RESP_OKAY;
            if (araddr[7:2] == psdp_pkg::REG_CTRL[7:2]) begin
                rdata_d = ctrl_q;
            end else if (araddr[7:2] == psdp_pkg::REG_STATUS[7:2]) begin
                rdata_d = statusWord;
            end else if (araddr[7:2] == psdp_pkg::REG_BEATS[7:2]) begin
                rdata_d = beatsWord;
            end else begin
                rdata_d = 32'h0000_0000;
                rresp_d = psdp_pkg::RESP_SLVERR;
            end
        end
    end

    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            awHave_q <= 1'b0;
            wHave_q <= 1'b0;
            awAddr_q <= 8'h00;
            wData_q <= 32'h0000_0000;
            wStrb_q <= 4'h0;
            bvalid_q <= 1'b0;
            bresp_q <= psdp_pkg::RESP_OKAY;
            rvalid_q <= 1'b0;
            rdata_q <= 32'h0000_0000;
            rresp_q <= psdp_pkg::RESP_OKAY;
            ctrl_q <= psdp_pkg::CTRL_RESET;
        end else begin
            awHave_q <= awHave_d;
            wHave_q <= wHave_d;
            awAddr_q <= awAddr_d;
            wData_q <= wData_d;
            wStrb_q <= wStrb_d;
            bvalid_q <= bvalid_d;
            bresp_q <= bresp_d;
            rvalid_q <= rvalid_d;
            rdata_q <= rdata_d;
            rresp_q <= rresp_d;
            ctrl_q <= ctrl_d;
        end
    end

    // ready flags are registered: a held half blocks the next until the write lands
    assign awready = ~awHave_q;
    assign wready = ~wHave_q;
    assign bvalid = bvalid_q;
    assign bresp = bresp_q;
    assign arready = ~rvalid_q;
    assign rvalid = rvalid_q;
    assign rdata = rdata_q;
    assign rresp = rresp_q;

endmodule : psdp_sram_port

// ### psdp_pkg.sv
// shared constants and types for the pipelined sram data port
package psdp_pkg;

    // register map, byte addresses on the 32-bit bus
    localparam logic [7:0] REG_CTRL = 8'h00;
    localparam logic [7:0] REG_STATUS = 8'h04;
    localparam logic [7:0] REG_BEATS = 8'h08;

    // control register fields
    localparam int unsigned CTRL_WPROT_BIT = 0;
    localparam logic [31:0] CTRL_RESET = 32'h0000_0000;

    // status register fields
    localparam int unsigned STAT_INTERLEAVED_BIT = 0;
    localparam int unsigned STAT_BURST_ACTIVE_BIT = 1;
    localparam int unsigned STAT_BURST_WRITE_BIT = 2;
    localparam int unsigned STAT_DRIVING_BIT = 3;

    // beat counter register fields
    localparam int unsigned BEATS_RD_LSB = 0;
    localparam int unsigned BEATS_WR_LSB = 16;
    localparam int unsigned BEATS_W = 16;

    // bus responses
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    // array geometry
    localparam int unsigned LANE_DATA_W = 8;
    localparam int unsigned LANE_W = 9;
    localparam int unsigned BURST_W = 2;

    typedef enum logic [1:0] {
        OP_IDLE = 2'b00,
        OP_READ = 2'b01,
        OP_WRITE = 2'b10
    } psdp_op_e;

    // synchronous control pins sampled at each qualified edge
    typedef struct packed {
        logic selectAN;
        logic selectB;
        logic selectCN;
        logic writeReqN;
        logic advanceOrLoad;
    } psdp_ctrl_s;

endpackage : psdp_pkg

// ### psdp_burst_seq.sv
// two-bit burst address sequencer, linear or interleaved
`timescale 1ns/10ps
module psdp_burst_seq (
    input wire logic [1:0] startLow,
    input wire logic [1:0] beat,
    input wire logic interleaved,
    output logic [1:0] burstLow
);

    always_comb begin
        if (interleaved) begin
            burstLow = startLow ^ beat;
        end else begin
            burstLow = 2'(startLow + beat);
        end
    end

endmodule : psdp_burst_seq

// ### psdp_sram_port_properties.sv
// assertion checker for the sram lanes and bus handshakes of the data port
`timescale 1ns/10ps
module psdp_sram_port_properties #(
    parameter int unsigned LANES = 4
) (
    input wire logic core_clk,
    input wire logic rst_n,
    input wire logic clkQualifyN,
    input wire psdp_pkg::psdp_ctrl_s ctrlPins,
    input wire logic outputEnableN,
    input wire logic [LANES*8-1:0] dataOut,
    input wire logic [LANES-1:0] dataOe,
    input wire logic [LANES-1:0] parityIoLanesOe,
    input wire logic bvalid,
    input wire logic bready,
    input wire logic rvalid,
    input wire logic rready
);
    logic sel;
    logic loadEdge;
    assign sel = !ctrlPins.selectAN && ctrlPins.selectB && !ctrlPins.selectCN;
    assign loadEdge = !clkQualifyN && !ctrlPins.advanceOrLoad;
    default clocking cb @(posedge core_clk);
    endclocking
    default disable iff (!rst_n);
    property p_stretch;
        clkQualifyN |=> $stable(dataOut);
    endproperty
    a_stretch: assert property (p_stretch) else $error("data moved");
    property p_oe_off;
        outputEnableN |=> dataOe == '0;
    endproperty
    a_oe_off: assert property (p_oe_off) else $error("driven, enable high");
    property p_par;
        parityIoLanesOe == dataOe;
    endproperty
    a_par: assert property (p_par) else $error("parity enable differs");
    property p_wr_flt;
        loadEdge && sel && !ctrlPins.writeReqN ##1 !clkQualifyN |=> dataOe == '0;
    endproperty
    a_wr_flt: assert property (p_wr_flt) else $error("driven in write");
    property p_ds_flt;
        loadEdge && !sel ##1 !clkQualifyN |=> dataOe == '0;
    endproperty
    a_ds_flt: assert property (p_ds_flt) else $error("driven when off");
    property p_drive;
        loadEdge && sel && ctrlPins.writeReqN ##1 !clkQualifyN && !outputEnableN |=> dataOe == '1;
    endproperty
    a_drive: assert property (p_drive) else $error("read not driven");
    property p_bhold;
        bvalid && !bready |=> bvalid;
    endproperty
    a_bhold: assert property (p_bhold) else $error("bvalid dropped");
    property p_rhold;
        rvalid && !rready |=> rvalid;
    endproperty
    a_rhold: assert property (p_rhold) else $error("rvalid dropped");
endmodule : psdp_sram_port_properties

// ### psdp_ctrl_model.sv
// far-side memory controller model driving the sram pins
`timescale 1ns/10ps
module psdp_ctrl_model (
    input wire logic core_clk,
    input wire logic clkQualifyN,
    output psdp_pkg::psdp_ctrl_s ctrlPins,
    output logic [3:0] byteLaneWriteN,
    output logic [17:0] address,
    output logic [35:0] drvLanes
);
    logic [35:0] s1D;
    logic [35:0] s2D;
    logic s1V;
    logic s2V;
    initial begin
        ctrlPins = '{1'b1, 1'b0, 1'b1, 1'b1, 1'b0};
        byteLaneWriteN = 4'hF;
        address = 18'h0;
        drvLanes = 36'h0;
        s1V = 1'b0;
        s2V = 1'b0;
    end
    // write data two qualified edges after its beat
    always @(posedge core_clk) begin
        if (!clkQualifyN) begin
            s2V <= s1V;
            s2D <= s1D;
        end
        // released lanes toggle so stale data cannot pass
        drvLanes <= s2V ? s2D : ~drvLanes;
    end
    // one beat per cycle; deselect loads, never advances
    task automatic op(input logic sel, input logic load, input logic wr, input logic [17:0] a,
                      input logic [3:0] be, input logic [35:0] d);
        ctrlPins <= '{!sel, sel, !sel, !wr, !load};
        byteLaneWriteN <= be;
        address <= a;
        s1V <= sel && wr;
        s1D <= d;
        @(posedge core_clk);
    endtask : op
endmodule : psdp_ctrl_model

// ### psdp_sram_port_tb_top.sv
// self-checking bench for the pipelined sram data port
`timescale 1ns/10ps
module psdp_sram_port_tb_top;
    localparam int unsigned LANES = 4;
    logic core_clk, rst_n, clkQualifyN, outputEnableN, burstOrder, selRd;
    psdp_pkg::psdp_ctrl_s ctrlPins;
    logic [3:0] byteLaneWriteN, dataOe, parityIoLanesOut, parityIoLanesOe;
    wire logic [3:0] parityIoLanesIn;
    wire logic [31:0] dataIn;
    logic [3:0] wstrb, be;
    logic [17:0] address, rdA1, rdA2, bSt, base, a;
    logic [31:0] dataOut, wdata, rdata;
    logic [35:0] drvLanes, d;
    logic [35:0] mem [logic [17:0]];
    logic [7:0] awaddr, araddr;
    logic [1:0] bresp, rresp, bBeat;
    logic awvalid, awready, wvalid, wready, bvalid, bready, arvalid, arready, rvalid, rready;
    logic rdV1, rdV2, bRd;
    int err_count = 0;
    int num_checks = 0;
    int m, i;

    psdp_sram_port #(.ADDR_W(18), .LANES(LANES)) psdp_sram_port_i (.core_clk, .rst_n,
        .clkQualifyN, .ctrlPins, .byteLaneWriteN, .address, .outputEnableN, .burstOrder,
        .dataIn, .dataOut, .dataOe, .parityIoLanesIn, .parityIoLanesOut, .parityIoLanesOe,
        .awaddr, .awvalid, .awready, .wdata, .wstrb, .wvalid, .wready, .bresp, .bvalid,
        .bready, .araddr, .arvalid, .arready, .rdata, .rresp, .rvalid, .rready);
    psdp_ctrl_model psdp_ctrl_model_i (.core_clk, .clkQualifyN, .ctrlPins, .byteLaneWriteN,
        .address, .drvLanes);

    // shared lanes: the device wins wherever it drives
    for (genvar g = 0; g < 4; g++) begin : g_lane
        assign dataIn[8*g+:8] = dataOe[g] ? dataOut[8*g+:8] : drvLanes[8*g+:8];
        assign parityIoLanesIn[g] = parityIoLanesOe[g] ? parityIoLanesOut[g] : drvLanes[32+g];
    end
    assign selRd = !ctrlPins.selectAN && ctrlPins.selectB && !ctrlPins.selectCN
        && ctrlPins.writeReqN;

    initial begin
        core_clk = 1'b0;
        forever #5 core_clk = ~core_clk;
    end

    function automatic logic [1:0] lowOf(input logic [1:0] s, input logic [1:0] b,
                                         input logic il);
        return il ? (s ^ b) : (s + b);
    endfunction : lowOf

    function automatic logic [35:0] merge(input logic [35:0] o, input logic [35:0] n,
                                          input logic [3:0] en);
        merge = o;
        for (int k = 0; k < 4; k++) begin
            if (!en[k]) begin
                merge[8*k+:8] = n[8*k+:8];
                merge[32+k] = n[32+k];
            end
        end
    endfunction : merge

    task automatic finish_test;
        if (err_count == 0 && num_checks > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask : finish_test

    task automatic chk(input logic [35:0] got, input logic [35:0] want);
        num_checks++;
        if (got !== want) begin
            err_count++;
            $display("ERROR %0t got %h want %h", $time, got, want);
        end
    endtask : chk

    task automatic axiWr(input logic [7:0] ad, input logic [31:0] dt);
        int n;
        awaddr <= ad;
        wdata <= dt;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        for (n = 0; n < 40; n++) begin
            @(posedge core_clk);
            if (bvalid && bready) break;
            if (awready) awvalid <= 1'b0;
            if (wready) wvalid <= 1'b0;
            bready <= (n >= 3);
        end
        bready <= 1'b0;
        chk({34'h0, bresp}, {34'h0, psdp_pkg::RESP_OKAY});
        if (n == 40) begin
            err_count++;
            finish_test();
        end
    endtask : axiWr

    task automatic axiRd(input logic [7:0] ad, input logic [31:0] mask, input logic [33:0] want);
        int n;
        araddr <= ad;
        arvalid <= 1'b1;
        for (n = 0; n < 40; n++) begin
            @(posedge core_clk);
            if (rvalid && rready) break;
            if (arready) arvalid <= 1'b0;
            rready <= (n >= 2);
        end
        rready <= 1'b0;
        chk({2'h0, rresp, rdata & mask}, {2'h0, want});
        if (n == 40) begin
            err_count++;
            finish_test();
        end
    endtask : axiRd

    task automatic idle(input int n);
        repeat (n) psdp_ctrl_model_i.op(1'b0, 1'b1, 1'b0, base, 4'hF, 36'h0);
    endtask : idle

    // track reads and burst beats on qualified edges
    always @(posedge core_clk) begin
        if (!rst_n) begin
            rdV1 <= 1'b0;
            rdV2 <= 1'b0;
            bRd <= 1'b0;
        end else if (!clkQualifyN) begin
            rdV2 <= rdV1;
            rdA2 <= rdA1;
            if (!ctrlPins.advanceOrLoad) begin
                bRd <= selRd;
                rdV1 <= selRd;
                bSt <= address;
                rdA1 <= address;
                bBeat <= 2'h0;
            end else begin
                bBeat <= bBeat + 2'h1;
                rdV1 <= bRd;
                rdA1 <= {bSt[17:2], lowOf(bSt[1:0], bBeat + 2'h1, burstOrder)};
            end
        end
    end

    always @(negedge core_clk) begin
        if (rst_n && rdV2) begin
            chk({parityIoLanesOut, dataOut}, mem[rdA2]);
        end
    end

    initial begin
        void'($urandom(17413));
        {rst_n, clkQualifyN, outputEnableN, awvalid, wvalid, bready, arvalid, rready} <= '0;
        {awaddr, araddr, wdata} <= '0;
        wstrb <= 4'hF;
        burstOrder <= 1'b1;
        base = 18'h0;
        for (m = 0; m < 2; m++) begin
            // strap moves only under reset; 1 stands for floating
            burstOrder <= m[0];
            rst_n <= 1'b0;
            repeat (10) @(posedge core_clk);
            rst_n <= 1'b1;
            axiRd(psdp_pkg::REG_CTRL, 32'hFFFFFFFF, {psdp_pkg::RESP_OKAY, psdp_pkg::CTRL_RESET});
            axiRd(psdp_pkg::REG_STATUS, 32'h1, {psdp_pkg::RESP_OKAY, 31'h0, m[0]});
            axiRd(8'h0C, 32'hFFFFFFFF, {psdp_pkg::RESP_SLVERR, 32'h0});
            // odd start low bits make linear and interleaved orders differ
            base = {17'($urandom), 1'b1};
            // write burst, then a random byte write at once
            for (i = 0; i < 5; i++) begin
                a = i < 4 ? {base[17:2], lowOf(base[1:0], 2'(i), m[0])} : base;
                d = 36'({$urandom, $urandom});
                be = i < 4 ? 4'h0 : 4'($urandom);
                mem[a] = i < 4 ? d : merge(mem[a], d, be);
                psdp_ctrl_model_i.op(1'b1, i == 0 || i == 4, 1'b1, a, be, d);
            end
            idle(2);
            // single reads back to back, one with output enable high
            for (i = 0; i < 4; i++) begin
                outputEnableN <= (i == 1);
                psdp_ctrl_model_i.op(1'b1, 1'b1, 1'b0, {base[17:2], 2'(i)}, 4'hF, 36'h0);
            end
            outputEnableN <= 1'b0;
            // read burst stretched in mid-flight
            for (i = 0; i < 4; i++) begin
                psdp_ctrl_model_i.op(1'b1, i == 0, 1'b0, base, 4'hF, 36'h0);
                if (i == 2) begin
                    clkQualifyN <= 1'b1;
                    repeat (3) @(posedge core_clk);
                    clkQualifyN <= 1'b0;
                end
            end
            idle(3);
            // protected write must leave the word alone
            axiWr(psdp_pkg::REG_CTRL, 32'h1);
            psdp_ctrl_model_i.op(1'b1, 1'b1, 1'b1, base, 4'h0, ~mem[base]);
            idle(2);
            axiWr(psdp_pkg::REG_CTRL, 32'h0);
            psdp_ctrl_model_i.op(1'b1, 1'b1, 1'b0, base, 4'hF, 36'h0);
            idle(3);
            // six write beats and nine read beats per pass; stretched edges add none
            axiRd(psdp_pkg::REG_BEATS, 32'hFFFFFFFF,
                  {psdp_pkg::RESP_OKAY, 32'h0006_0009});
        end
        finish_test();
    end
endmodule : psdp_sram_port_tb_top

bind psdp_sram_port psdp_sram_port_properties #(.LANES(LANES)) psdp_sram_port_properties_i (
    .core_clk, .rst_n, .clkQualifyN, .ctrlPins, .outputEnableN, .dataOut, .dataOe,
    .parityIoLanesOe, .bvalid, .bready, .rvalid, .rready);
